// [hdl/frd_defs.vh]
`ifndef FRD_DEFS_VH
`define FRD_DEFS_VH
`define FRD_CLK_KHZ 40000
`define FRD_RETAIN_MS 15000
`define FRD_BEEP_MS 200
`define FRD_ALARM_SLOTS 4'ha
`define FRD_LONG_MS 1000
`define FRD_DEBOUNCE_MS 10
`define FRD_SEV_INFO 2'h0
`define FRD_SEV_NONCRIT 2'h1
`define FRD_SEV_CRIT 2'h2
`define FRD_SEV_UNREC 2'h3
`define FRD_BEEPS_INFO 3'h1
`define FRD_BEEPS_NONCRIT 3'h2
`define FRD_BEEPS_CRIT 3'h3
`define FRD_QDEPTH 8
`define FRD_QIW 3
`define FRD_SEQW 16
`define FRD_TMRW 30
`define FRD_BTNW 26
`define FRD_BEEPW 23
`define FRD_V_IDLE 5'h01
`define FRD_V_BANNER 5'h02
`define FRD_V_CLASS 5'h04
`define FRD_V_UNIT 5'h08
`define FRD_V_CODE 5'h10
`endif

// [hdl/frd_fault_display.v]
`timescale 1ns/1ps
`include "frd_defs.vh"

module frd_button #(
    parameter DEB_CYC = 1,
    parameter LONG_CYC = 2
) (
    input wire clk_in,
    input wire arst_n_in,
    input wire btn_n_in,
    output reg short_out,
    output reg long_out
);
    reg sync1;
    reg sync2;
    reg pressed;
    reg long_done;
    reg [`FRD_BTNW-1:0] deb_cnt;
    reg [`FRD_BTNW-1:0] hold_cnt;

    always @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            sync1 <= 1'b1;
            sync2 <= 1'b1;
            pressed <= 1'b0;
            long_done <= 1'b0;
            deb_cnt <= {`FRD_BTNW{1'b0}};
            hold_cnt <= {`FRD_BTNW{1'b0}};
            short_out <= 1'b0;
            long_out <= 1'b0;
        end else begin
            sync1 <= btn_n_in;
            sync2 <= sync1;
            short_out <= 1'b0;
            long_out <= 1'b0;
            // level must hold steady for the whole window
            if (~sync2 == pressed) begin
                deb_cnt <= {`FRD_BTNW{1'b0}};
            end else if (deb_cnt == DEB_CYC[`FRD_BTNW-1:0] - 1'b1) begin
                deb_cnt <= {`FRD_BTNW{1'b0}};
                pressed <= ~sync2;
                if (sync2 && !long_done) begin
                    short_out <= 1'b1;
                end
            end else begin
                deb_cnt <= deb_cnt + 1'b1;
            end
            if (!pressed) begin
                hold_cnt <= {`FRD_BTNW{1'b0}};
                long_done <= 1'b0;
            end else if (!long_done) begin
                if (hold_cnt == LONG_CYC[`FRD_BTNW-1:0] - 1'b1) begin
                    long_out <= 1'b1;
                    long_done <= 1'b1;
                end else begin
                    hold_cnt <= hold_cnt + 1'b1;
                end
            end
        end
    end
endmodule // frd_button

module frd_fault_display #(
    parameter RETAIN_CYC = `FRD_RETAIN_MS * `FRD_CLK_KHZ,
    parameter BEEP_CYC = `FRD_BEEP_MS * `FRD_CLK_KHZ,
    parameter LONG_CYC = `FRD_LONG_MS * `FRD_CLK_KHZ,
    parameter DEB_CYC = `FRD_DEBOUNCE_MS * `FRD_CLK_KHZ
) (
    input wire clk_in,
    input wire arst_n_in,
    input wire cond_valid_in,
    input wire [1:0] cond_sev_in,
    input wire [7:0] cond_class_in,
    input wire [6:0] cond_unit_in,
    input wire [6:0] cond_code_in,
    input wire clr_valid_in,
    input wire [7:0] clr_class_in,
    input wire [6:0] clr_unit_in,
    input wire [6:0] clr_code_in,
    input wire mute_toggle_in,
    input wire alarm_disable_in,
    input wire btn_top_n_in,
    input wire btn_bot_n_in,
    output reg alarm_out,
    output reg top_led_out,
    output reg fault_menu_out,
    output reg [4:0] disp_view_out,
    output reg [3:0] disp_hi_out,
    output reg [3:0] disp_lo_out,
    output reg disp_dp_hi_out,
    output reg disp_dp_lo_out,
    output reg ctrl_valid_out,
    output reg [1:0] ctrl_sev_out,
    output reg [7:0] ctrl_class_out,
    output reg [6:0] ctrl_unit_out,
    output reg [6:0] ctrl_code_out
);
    localparam V_IDLE = `FRD_V_IDLE;
    localparam V_BANNER = `FRD_V_BANNER;
    localparam V_CLASS = `FRD_V_CLASS;
    localparam V_UNIT = `FRD_V_UNIT;
    localparam V_CODE = `FRD_V_CODE;
    localparam KW = 2 + `FRD_SEQW;

    reg q_valid [0:`FRD_QDEPTH-1];
    reg q_fixed [0:`FRD_QDEPTH-1];
    reg [1:0] q_sev [0:`FRD_QDEPTH-1];
    reg [7:0] q_class [0:`FRD_QDEPTH-1];
    reg [6:0] q_unit [0:`FRD_QDEPTH-1];
    reg [6:0] q_code [0:`FRD_QDEPTH-1];
    reg [`FRD_SEQW-1:0] q_seq [0:`FRD_QDEPTH-1];
    reg [`FRD_TMRW-1:0] q_tmr [0:`FRD_QDEPTH-1];
    reg [`FRD_SEQW-1:0] seq;
    reg [`FRD_QIW-1:0] cur;
    reg jump;
    reg [4:0] view;
    reg muted;
    reg [`FRD_BEEPW-1:0] beep_cnt;
    reg [3:0] slot;
    wire top_short;
    wire top_long;
    wire bot_short;

    // combinational picks over the queue
    reg any;
    reg has_free;
    reg has_next;
    reg [`FRD_QIW-1:0] free_idx;
    reg [`FRD_QIW-1:0] best_idx;
    reg [`FRD_QIW-1:0] next_idx;
    reg [KW-1:0] best_key;
    reg [KW-1:0] next_key;
    reg [KW-1:0] cur_key;
    reg [KW-1:0] k;
    integer i;
    // own loop index: the queue process must not share one with the picks
    integer j;

    // lower key first: severity inverted, then age
    function [KW-1:0] key_of;
        input [1:0] sev;
        input [`FRD_SEQW-1:0] s;
        begin
            key_of = {~sev, s};
        end
    endfunction

    function [7:0] to_dec;
        input [6:0] v;
        integer t;
        reg [6:0] r;
        begin
            r = v;
            to_dec = 8'h00;
            for (t = 9; t > 0; t = t - 1) begin
                if (to_dec[7:4] == 4'h0 && v >= t * 10) begin
                    to_dec[7:4] = t[3:0];
                    r = v - t[6:0] * 7'h0a;
                end
            end
            to_dec[3:0] = r[3:0];
        end
    endfunction

    always @* begin
        any = 1'b0;
        has_free = 1'b0;
        has_next = 1'b0;
        free_idx = {`FRD_QIW{1'b0}};
        best_idx = {`FRD_QIW{1'b0}};
        next_idx = {`FRD_QIW{1'b0}};
        best_key = {KW{1'b1}};
        next_key = {KW{1'b1}};
        cur_key = key_of(q_sev[cur], q_seq[cur]);
        k = {KW{1'b0}};
        for (j = `FRD_QDEPTH - 1; j >= 0; j = j - 1) begin
            k = key_of(q_sev[j], q_seq[j]);
            if (!q_valid[j]) begin
                has_free = 1'b1;
                free_idx = j[`FRD_QIW-1:0];
            end else begin
                if (!any || k < best_key) begin
                    best_key = k;
                    best_idx = j[`FRD_QIW-1:0];
                end
                if (k > cur_key && (!has_next || k < next_key)) begin
                    next_key = k;
                    next_idx = j[`FRD_QIW-1:0];
                    has_next = 1'b1;
                end
                any = 1'b1;
            end
        end
    end

    frd_button #(.DEB_CYC(DEB_CYC), .LONG_CYC(LONG_CYC)) u_top (
        .clk_in(clk_in),
        .arst_n_in(arst_n_in),
        .btn_n_in(btn_top_n_in),
        .short_out(top_short),
        .long_out(top_long)
    );

    frd_button #(.DEB_CYC(DEB_CYC), .LONG_CYC(LONG_CYC)) u_bot (
        .clk_in(clk_in),
        .arst_n_in(arst_n_in),
        .btn_n_in(btn_bot_n_in),
        .short_out(bot_short),
        .long_out()
    );

    // queue: a new report wins over a clear of the same slot
    always @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            seq <= {`FRD_SEQW{1'b0}};
            for (i = 0; i < `FRD_QDEPTH; i = i + 1) begin
                q_valid[i] <= 1'b0;
                q_fixed[i] <= 1'b0;
                q_sev[i] <= 2'h0;
                q_class[i] <= 8'h00;
                q_unit[i] <= 7'h00;
                q_code[i] <= 7'h00;
                q_seq[i] <= {`FRD_SEQW{1'b0}};
                q_tmr[i] <= {`FRD_TMRW{1'b0}};
            end
        end else begin
            // sequence wraps after 65536 reports; order then skews
            if (cond_valid_in) begin
                seq <= seq + 1'b1;
            end
            for (i = 0; i < `FRD_QDEPTH; i = i + 1) begin
                if (cond_valid_in && has_free && free_idx == i) begin
                    q_valid[i] <= 1'b1;
                    q_fixed[i] <= 1'b0;
                    q_sev[i] <= cond_sev_in;
                    q_class[i] <= cond_class_in;
                    q_unit[i] <= cond_unit_in;
                    q_code[i] <= cond_code_in;
                    q_seq[i] <= seq;
                    q_tmr[i] <= RETAIN_CYC[`FRD_TMRW-1:0];
                end else if (q_valid[i]) begin
                    if (q_tmr[i] != {`FRD_TMRW{1'b0}}) begin
                        q_tmr[i] <= q_tmr[i] - 1'b1;
                    end
                    if (clr_valid_in && clr_class_in == q_class[i] &&
                        clr_unit_in == q_unit[i] &&
                        clr_code_in == q_code[i]) begin
                        q_fixed[i] <= 1'b1;
                    end
                    // only a corrected, aged report leaves
                    if (q_fixed[i] && q_tmr[i] == {`FRD_TMRW{1'b0}}) begin
                        q_valid[i] <= 1'b0;
                    end
                end
            end
        end
    end

    // navigation and display
    always @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            view <= V_IDLE;
            cur <= {`FRD_QIW{1'b0}};
            jump <= 1'b0;
        end else begin
            jump <= cond_valid_in && cond_sev_in > q_sev[cur];
            case (view)
            V_IDLE: begin
                if (any) begin
                    view <= V_BANNER;
                end
            end
            V_BANNER: begin
                cur <= best_idx;
                if (!any) begin
                    view <= V_IDLE;
                end else if (top_long) begin
                    view <= V_CLASS;
                end
            end
            V_CLASS, V_UNIT, V_CODE: begin
                if (!any) begin
                    view <= V_IDLE;
                end else if (jump || !q_valid[cur]) begin
                    cur <= best_idx;
                end else if (bot_short) begin
                    view <= V_BANNER;
                end else if (top_long) begin
                    cur <= has_next ? next_idx : best_idx;
                    view <= V_CLASS;
                end else if (top_short) begin
                    view <= (view == V_CLASS) ? V_UNIT :
                            (view == V_UNIT) ? V_CODE : V_CLASS;
                end
            end
            default: begin
                view <= V_IDLE;
            end
            endcase
        end
    end

    always @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            disp_view_out <= V_IDLE;
            disp_hi_out <= 4'h0;
            disp_lo_out <= 4'h0;
            disp_dp_hi_out <= 1'b0;
            disp_dp_lo_out <= 1'b0;
            top_led_out <= 1'b0;
            fault_menu_out <= 1'b0;
            ctrl_valid_out <= 1'b0;
            ctrl_sev_out <= 2'h0;
            ctrl_class_out <= 8'h00;
            ctrl_unit_out <= 7'h00;
            ctrl_code_out <= 7'h00;
        end else begin
            disp_view_out <= view;
            top_led_out <= any;
            fault_menu_out <= any;
            ctrl_valid_out <= cond_valid_in;
            if (cond_valid_in) begin
                ctrl_sev_out <= cond_sev_in;
                ctrl_class_out <= cond_class_in;
                ctrl_unit_out <= cond_unit_in;
                ctrl_code_out <= cond_code_in;
            end
            disp_dp_hi_out <= view == V_CLASS;
            disp_dp_lo_out <= view == V_CLASS || view == V_UNIT;
            if (view == V_CLASS) begin
                {disp_hi_out, disp_lo_out} <= q_class[cur];
            end else if (view == V_UNIT) begin
                {disp_hi_out, disp_lo_out} <= to_dec(q_unit[cur]);
            end else if (view == V_CODE) begin
                {disp_hi_out, disp_lo_out} <= to_dec(q_code[cur]);
            end else begin
                {disp_hi_out, disp_lo_out} <= 8'h00;
            end
        end
    end

    // alarm: slots of one beep length, even slots may sound, every slot for unrecoverable
    always @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            muted <= 1'b0;
            beep_cnt <= {`FRD_BEEPW{1'b0}};
            slot <= 4'h0;
            alarm_out <= 1'b0;
        end else begin
            if (cond_valid_in) begin
                muted <= 1'b0;
            end else if (mute_toggle_in) begin
                muted <= ~muted;
            end
            if (!any || muted || alarm_disable_in) begin
                beep_cnt <= {`FRD_BEEPW{1'b0}};
                slot <= 4'h0;
                alarm_out <= 1'b0;
            end else begin
                if (beep_cnt == BEEP_CYC[`FRD_BEEPW-1:0] - 1'b1) begin
                    beep_cnt <= {`FRD_BEEPW{1'b0}};
                    slot <= (slot == `FRD_ALARM_SLOTS - 1'b1) ? 4'h0 :
                            slot + 1'b1;
                end else begin
                    beep_cnt <= beep_cnt + 1'b1;
                end
                case (q_sev[best_idx])
                `FRD_SEV_UNREC: alarm_out <= 1'b1;
                `FRD_SEV_CRIT:
                    alarm_out <= !slot[0] &&
                        slot[3:1] < `FRD_BEEPS_CRIT;
                `FRD_SEV_NONCRIT:
                    alarm_out <= !slot[0] &&
                        slot[3:1] < `FRD_BEEPS_NONCRIT;
                default:
                    alarm_out <= !slot[0] &&
                        slot[3:1] < `FRD_BEEPS_INFO;
                endcase
            end
        end
    end
endmodule // frd_fault_display

// [tb/frd_fault_display_sva.sv]
`timescale 1ns/1ps
module frd_fault_display_sva (
    input wire clk_in,
    input wire arst_n_in,
    input wire cond_valid_in,
    input wire [7:0] cond_class_in,
    input wire [6:0] cond_code_in,
    input wire alarm_disable_in,
    input wire alarm_out,
    input wire top_led_out,
    input wire fault_menu_out,
    input wire [4:0] disp_view_out,
    input wire disp_dp_hi_out,
    input wire disp_dp_lo_out,
    input wire ctrl_valid_out,
    input wire [7:0] ctrl_class_out,
    input wire [6:0] ctrl_code_out
);
    default clocking @(posedge clk_in);
    endclocking
    default disable iff (!arst_n_in);

    fwd_pulse_a: assert property (cond_valid_in |=> ctrl_valid_out)
        else $error("report not forwarded");
    fwd_fields_a: assert property (cond_valid_in |=>
        ctrl_class_out == $past(cond_class_in)
        && ctrl_code_out == $past(cond_code_in))
        else $error("forwarded fields differ");
    led_raise_a: assert property (cond_valid_in |-> ##2 top_led_out)
        else $error("top led late");
    menu_led_a: assert property (top_led_out == fault_menu_out)
        else $error("fault menu and led disagree");
    banner_entry_a: assert property (
        cond_valid_in && !top_led_out && disp_view_out == 5'h01
        |-> ##3 disp_view_out == 5'h02)
        else $error("banner not shown");
    idle_empty_a: assert property (!top_led_out [*3]
        |-> disp_view_out == 5'h01)
        else $error("view not idle while empty");
    quiet_empty_a: assert property (!top_led_out [*3] |-> !alarm_out)
        else $error("alarm with empty queue");
    dis_quiet_a: assert property (alarm_disable_in [*3] |-> !alarm_out)
        else $error("alarm while disabled");
    class_dp_a: assert property (disp_view_out == 5'h04
        |-> disp_dp_hi_out && disp_dp_lo_out)
        else $error("class points wrong");
    unit_dp_a: assert property (disp_view_out == 5'h08
        |-> !disp_dp_hi_out && disp_dp_lo_out)
        else $error("unit points wrong");
    code_dp_a: assert property (disp_view_out == 5'h10
        |-> !disp_dp_hi_out && !disp_dp_lo_out)
        else $error("code points wrong");
endmodule // frd_fault_display_sva

// [tb/frd_panel.sv]
`timescale 1ns/1ps
module frd_panel (
    input wire clk_in,
    output logic btn_top_n_out,
    output logic btn_bot_n_out
);
    // a released button sits at its pull-up level
    initial begin
        btn_top_n_out = 1'b1;
        btn_bot_n_out = 1'b1;
    end
    task automatic press(input bit top, input int cyc);
        if (top) btn_top_n_out = 1'b0;
        else btn_bot_n_out = 1'b0;
        repeat (cyc) @(posedge clk_in);
        #1;
        btn_top_n_out = 1'b1;
        btn_bot_n_out = 1'b1;
        // room for sync, debounce and view update
        repeat (12) @(posedge clk_in);
        #1;
    endtask
endmodule // frd_panel

// [tb/frd_fault_display_tb.sv]
`timescale 1ns/1ps
module frd_fault_display_tb;
    logic clk_in = 1'b0, arst_n_in = 1'b0;
    logic cond_valid_in = 1'b0, clr_valid_in = 1'b0;
    logic mute_toggle_in = 1'b0, alarm_disable_in = 1'b0;
    logic [1:0] cond_sev_in = 2'h0;
    logic [7:0] cond_class_in = 8'h00, clr_class_in = 8'h00;
    logic [6:0] cond_unit_in = 7'h00, cond_code_in = 7'h00;
    logic [6:0] clr_unit_in = 7'h00, clr_code_in = 7'h00;
    wire btn_top_n, btn_bot_n, alarm_out, top_led_out, fault_menu_out;
    wire disp_dp_hi_out, disp_dp_lo_out, ctrl_valid_out;
    wire [4:0] disp_view_out;
    wire [3:0] disp_hi_out, disp_lo_out;
    wire [1:0] ctrl_sev_out;
    wire [7:0] ctrl_class_out;
    wire [6:0] ctrl_unit_out, ctrl_code_out;
    int n_mismatch = 0, n_checks = 0;

    always #12.5 clk_in = ~clk_in;

    frd_fault_display #(.RETAIN_CYC(50), .BEEP_CYC(4), .LONG_CYC(20),
        .DEB_CYC(3)) i_dut (.clk_in, .arst_n_in, .cond_valid_in,
        .cond_sev_in, .cond_class_in, .cond_unit_in, .cond_code_in,
        .clr_valid_in, .clr_class_in, .clr_unit_in, .clr_code_in,
        .mute_toggle_in, .alarm_disable_in, .btn_top_n_in(btn_top_n),
        .btn_bot_n_in(btn_bot_n), .alarm_out, .top_led_out,
        .fault_menu_out, .disp_view_out, .disp_hi_out, .disp_lo_out,
        .disp_dp_hi_out, .disp_dp_lo_out, .ctrl_valid_out, .ctrl_sev_out,
        .ctrl_class_out, .ctrl_unit_out, .ctrl_code_out);
    frd_panel i_panel (.clk_in, .btn_top_n_out(btn_top_n),
        .btn_bot_n_out(btn_bot_n));

    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask
    task automatic chk(input logic [31:0] got, exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rep(input logic [1:0] s, input logic [7:0] c,
        input logic [6:0] u, k);
        {cond_sev_in, cond_class_in, cond_unit_in, cond_code_in} = {s, c, u, k};
        cond_valid_in = 1'b1;
        tick(1);
        cond_valid_in = 1'b0;
        chk({ctrl_valid_out, ctrl_sev_out, ctrl_class_out, ctrl_unit_out,
            ctrl_code_out}, {1'b1, s, c, u, k});
        tick(1);
        chk({ctrl_valid_out, top_led_out}, 2'h1);
    endtask
    task automatic clr(input logic [7:0] c, input logic [6:0] u, k);
        {clr_class_in, clr_unit_in, clr_code_in} = {c, u, k};
        clr_valid_in = 1'b1;
        tick(1);
        clr_valid_in = 1'b0;
        tick(1);
    endtask
    // one alarm cycle is 10 slots of 4 clocks
    task automatic alarm_chk(input int rises, highs);
        int r = 0;
        int h = 0;
        logic prev;
        tick(4);
        prev = alarm_out;
        repeat (40) begin
            tick(1);
            if (alarm_out === 1'b1 && prev === 1'b0) r++;
            if (alarm_out === 1'b1) h++;
            prev = alarm_out;
        end
        chk(r, rises);
        chk(h, highs);
    endtask
    task automatic view_chk(input logic [4:0] v, input logic [3:0] hi, lo,
        input logic [1:0] dp);
        chk({disp_view_out, disp_hi_out, disp_lo_out, disp_dp_hi_out,
            disp_dp_lo_out}, {v, hi, lo, dp});
    endtask

    task automatic t_levels();
        rep(2'h0, 8'h1a, 7'h2f, 7'h55);
        tick(1);
        view_chk(5'h02, 4'h0, 4'h0, 2'h0);
        alarm_chk(1, 4);
        rep(2'h1, 8'h2b, 7'h03, 7'h09);
        alarm_chk(2, 8);
    endtask
    task automatic t_nav();
        i_panel.press(1'b1, 28);
        view_chk(5'h04, 4'h2, 4'hb, 2'h3);
        i_panel.press(1'b1, 10);
        view_chk(5'h08, 4'h0, 4'h3, 2'h1);
        i_panel.press(1'b1, 10);
        view_chk(5'h10, 4'h0, 4'h9, 2'h0);
        i_panel.press(1'b1, 10);
        view_chk(5'h04, 4'h2, 4'hb, 2'h3);
        i_panel.press(1'b1, 28);
        view_chk(5'h04, 4'h1, 4'ha, 2'h3);
        rep(2'h2, 8'hc3, 7'h0a, 7'h0b);
        tick(3);
        view_chk(5'h04, 4'hc, 4'h3, 2'h3);
        alarm_chk(3, 12);
        rep(2'h3, 8'hff, 7'h63, 7'h01);
        alarm_chk(0, 40);
        view_chk(5'h04, 4'hf, 4'hf, 2'h3);
        i_panel.press(1'b1, 28);
        view_chk(5'h04, 4'hc, 4'h3, 2'h3);
        i_panel.press(1'b0, 10);
        view_chk(5'h02, 4'h0, 4'h0, 2'h0);
    endtask
    task automatic t_mute();
        mute_toggle_in = 1'b1;
        tick(1);
        mute_toggle_in = 1'b0;
        alarm_chk(0, 0);
        chk(top_led_out, 1);
        rep(2'h0, 8'h01, 7'h00, 7'h00);
        alarm_chk(0, 40);
        alarm_disable_in = 1'b1;
        rep(2'h0, 8'h01, 7'h00, 7'h02);
        alarm_chk(0, 0);
        view_chk(5'h02, 4'h0, 4'h0, 2'h0);
        alarm_disable_in = 1'b0;
    endtask
    task automatic t_retain();
        arst_n_in = 1'b0;
        tick(2);
        chk({top_led_out, disp_view_out}, 6'h01);
        arst_n_in = 1'b1;
        tick(1);
        rep(2'h0, 8'h1a, 7'h2f, 7'h55);
        rep(2'h0, 8'h2b, 7'h03, 7'h09);
        clr(8'h1a, 7'h2f, 7'h55);
        // wrong code must not match
        clr(8'h2b, 7'h03, 7'h08);
        i_panel.press(1'b1, 28);
        view_chk(5'h04, 4'h1, 4'ha, 2'h3);
        i_panel.press(1'b0, 10);
        tick(40);
        i_panel.press(1'b1, 28);
        view_chk(5'h04, 4'h2, 4'hb, 2'h3);
        clr(8'h2b, 7'h03, 7'h09);
        tick(70);
        chk({top_led_out, disp_view_out}, 6'h01);
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial begin
        tick(4);
        arst_n_in = 1'b1;
        tick(1);
        t_levels();
        t_nav();
        t_mute();
        t_retain();
        final_report();
    end
    // the whole run needs well under 3000 clocks
    initial begin
        repeat (20000) @(posedge clk_in);
        n_mismatch++;
        final_report();
    end
endmodule // frd_fault_display_tb

bind frd_fault_display frd_fault_display_sva i_sva (.clk_in, .arst_n_in,
    .cond_valid_in, .cond_class_in, .cond_code_in, .alarm_disable_in,
    .alarm_out, .top_led_out, .fault_menu_out, .disp_view_out,
    .disp_dp_hi_out, .disp_dp_lo_out, .ctrl_valid_out, .ctrl_class_out,
    .ctrl_code_out);
